//--- include/wwdfr_pkg.sv
package wwdfr_pkg;

    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 10000;
    // Rounded down: the tick may run slightly fast, never slow
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_MS = 1000000 / TICK_NS;

    // ----------------------------------------
    // Watchdog timing
    // ----------------------------------------
    localparam int FAULT_PULSE_US = 2000;
    localparam int FAULT_PULSE_TICKS = (FAULT_PULSE_US * 1000) / TICK_NS;
    localparam int ARM_DELAY_US = 30000;
    localparam int ARM_DELAY_TICKS = (ARM_DELAY_US * 1000) / TICK_NS;
    localparam int LATE_MIN_MS = 4;
    localparam int LATE_MAX_MS = 100;
    localparam int EARLY_SHIFT = 2;

    localparam int CNT_W = 16;
    localparam int DIV_W = 12;
    localparam int ADJ_W = 7;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [DIV_W-1:0] DIV_ZERO = 12'h000;
    localparam logic [DIV_W-1:0] DIV_ONE = 12'h001;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ARM_WAIT = 2'b01,
        ST_RUN = 2'b10,
        ST_PULSE = 2'b11
    } wwdfr_state_t;

    typedef struct packed {
        logic armed;
        logic early_fault;
        logic late_fault;
        logic ref_fault;
    } wwdfr_status_t;

endpackage

//--- test/wwdfr_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Host heartbeat source
// ----------------------------------------
module wwdfr_host_model (
    input wire logic i_sys_clk,
    input wire logic i_beat_on,
    input wire logic [15:0] i_period,
    output logic o_heartbeat
);
    logic [15:0] cnt_reg;

    initial cnt_reg = 16'h0000;

    // Steps off the falling edge so the block never samples a moving pin
    always @(negedge i_sys_clk) begin
        if (!i_beat_on || cnt_reg >= i_period - 16'h0001) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // One rising edge per period, half duty, held low while stopped
    assign o_heartbeat = i_beat_on && (cnt_reg < (i_period >> 1));
endmodule

//--- test/wwdfr_top_tb.sv
`timescale 1ns/100ps

module wwdfr_top_tb;
    import wwdfr_pkg::*;
    localparam int TCK = 4;
    localparam int ARM = 30;
    localparam int PUL = 4;
    // Late timeout in ticks at the smallest setting
    localparam int LATE4 = 400;

    logic clk = 1'b0;
    logic rst_n, hb_on, enable_n, regs_good, mref, hb;
    logic rst_oe, rst_out, v5_oe, v5_out, early_seen, late_seen, oe_seen;
    logic [15:0] period;
    logic [ADJ_W-1:0] adjust;
    wwdfr_status_t status;
    int n_fail = 0;
    int n_tests = 0;

    // Open-drain pins with pull-ups
    wire rst_pin = rst_oe ? rst_out : 1'b1;
    wire v5_pin = v5_oe ? v5_out : 1'b1;

    always #20 clk = ~clk;

    wwdfr_host_model host (
        .i_sys_clk(clk),
        .i_beat_on(hb_on),
        .i_period(period),
        .o_heartbeat(hb)
    );

    wwdfr_top #(.P_TICK_CYCLES(TCK), .P_ARM_TICKS(ARM), .P_PULSE_TICKS(PUL)) DUT (
        .i_sys_clk(clk),
        .i_rst_n(rst_n),
        .i_heartbeat_in(hb),
        .i_wdog_enable_n(enable_n),
        .i_regs_good(regs_good),
        .i_monitor_reference_fault(mref),
        .i_timeout_adjust(adjust),
        .i_reset_fault_n_in(rst_pin),
        .o_reset_fault_n_out(rst_out),
        .o_reset_fault_n_oe(rst_oe),
        .i_five_volt_good_in(v5_pin),
        .o_five_volt_good_out(v5_out),
        .o_five_volt_good_oe(v5_oe),
        .o_status(status)
    );

    // Fault pulses last one cycle, so keep a sticky copy
    always @(posedge clk) begin
        if (status.early_fault === 1'b1) early_seen <= 1'b1;
        if (status.late_fault === 1'b1) late_seen <= 1'b1;
        if (rst_oe === 1'b1) oe_seen <= 1'b1;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task print_verdict();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task in_range(input string name, input int n, input int lo, input int hi);
        check(name, 32'(n >= lo && n <= hi), 32'h0000_0001);
    endtask

    task clr();
        early_seen = 1'b0;
        late_seen = 1'b0;
        oe_seen = 1'b0;
    endtask

    // Bounded wait for the reset pin drive to reach a level
    task wait_oe(input logic lvl, input int lim, output int n);
        n = 0;
        while (rst_oe !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            n_fail++;
            $display("[ERR] wait_oe expected %0d seen timeout", lvl);
            print_verdict();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset();
        check("rst_oe", rst_oe, 0);
        check("v5_oe", v5_oe, 0);
        check("rst_out", rst_out, 0);
        check("v5_out", v5_out, 0);
        check("status", status, 0);
        $display("t_reset done");
    endtask

    task t_disabled();
        regs_good = 1'b1;
        clr();
        repeat (2500) @(negedge clk);
        check("oe_seen_off", oe_seen, 0);
        check("armed_off", status.armed, 0);
        enable_n = 1'b0;
        regs_good = 1'b0;
        repeat (300) @(negedge clk);
        check("armed_no_regs", status.armed, 0);
        $display("t_disabled done");
    endtask

    task t_arm();
        int n;
        n = 0;
        regs_good = 1'b1;
        while (status.armed !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        in_range("arm_delay", n, ARM * TCK - 4, ARM * TCK + 16);
        if (n >= 400) print_verdict();
        $display("t_arm done");
    endtask

    task t_missing();
        int n;
        clr();
        wait_oe(1'b1, 2000, n);
        in_range("late_time", n, LATE4 * TCK - 20, LATE4 * TCK + 10);
        wait_oe(1'b0, 100, n);
        in_range("pulse_len", n, PUL * TCK - 4, PUL * TCK + 4);
        // Sticky copies lag the status pulse by one edge, so look after the pulse
        check("late_seen", late_seen, 1);
        check("early_seen", early_seen, 0);
        wait_oe(1'b1, 2000, n);
        in_range("repeat_time", n, LATE4 * TCK - 20, LATE4 * TCK + 10);
        wait_oe(1'b0, 100, n);
        $display("t_missing done");
    endtask

    task t_good();
        period = 16'h0320;
        hb_on = 1'b1;
        clr();
        repeat (6000) @(negedge clk);
        check("oe_seen_good", oe_seen, 0);
        check("armed_good", status.armed, 1);
        // Longer timeout lets a wider spacing pass that the short one would reject
        @(posedge hb);
        @(negedge clk);
        adjust = 7'h08;
        period = 16'h07d0;
        repeat (8000) @(negedge clk);
        check("oe_seen_slow", oe_seen, 0);
        $display("t_good done");
    endtask

    task t_early();
        int n;
        @(posedge hb);
        @(negedge clk);
        period = 16'h0258;
        clr();
        n = 0;
        while (early_seen !== 1'b1 && n < 800) begin
            @(negedge clk);
            n++;
        end
        hb_on = 1'b0;
        check("early_seen", early_seen, 1);
        if (n >= 800) print_verdict();
        check("late_quiet", late_seen, 0);
        wait_oe(1'b0, 100, n);
        in_range("early_pulse", n, PUL * TCK - 5, PUL * TCK + 4);
        $display("t_early done");
    endtask

    task t_ref();
        int n;
        n = 0;
        mref = 1'b1;
        while (v5_oe !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        in_range("ref_delay", n, 2, 4);
        if (n >= 10) print_verdict();
        check("ref_rst_oe", rst_oe, 1);
        check("ref_status", status.ref_fault, 1);
        mref = 1'b0;
        repeat (6) @(negedge clk);
        check("ref_v5_clear", v5_oe, 0);
        check("ref_status_clear", status.ref_fault, 0);
        $display("t_ref done");
    endtask

    // Heartbeat is stopped here, so a still-armed watchdog would time out
    task t_disarm();
        enable_n = 1'b1;
        clr();
        repeat (4000) @(negedge clk);
        check("oe_seen_dis", oe_seen, 0);
        check("armed_dis", status.armed, 0);
        check("late_dis", late_seen, 0);
        $display("t_disarm done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        hb_on = 1'b0;
        period = 16'h0320;
        enable_n = 1'b1;
        regs_good = 1'b0;
        mref = 1'b0;
        adjust = 7'h04;
        clr();
        repeat (20) @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        t_disabled();
        t_arm();
        t_missing();
        t_good();
        t_early();
        t_ref();
        t_disarm();
        print_verdict();
    end
endmodule

//--- verilog/wwdfr_sync.sv
`timescale 1ns/100ps

// ----------------------------------------
// Two-stage level synchroniser
// ----------------------------------------
module wwdfr_sync (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule

//--- verilog/wwdfr_top.sv
`timescale 1ns/100ps

// Contract
// - Measure the spacing of heartbeat rising edges and fault when it falls outside the window.
// - An edge arriving before the early threshold since the previous edge is an early fault.
// - No edge before the late timeout since the previous edge is a late fault.
// - Any watchdog fault pulls the reset output low for a fixed pulse of about 2 ms.
// - The early threshold is one quarter of the late timeout.
// - The early threshold spans 1.0 ms to 25 ms.
// - The late timeout spans 4.0 ms to 100 ms.
// - Arm only while enable is low and regulators have been good for the 30 ms arm delay.
// - With no edges for arm delay plus late timeout, pulse reset and clear the counters.
// - Keep repeating that pulse while edges stay absent and stop once edges resume.
// - A bad monitoring reference still reports a fault on reset and 5 V good outputs.
// - Reset and 5 V good are open-drain active-low indicators pulled low on fault.
module wwdfr_top #(
    parameter int P_TICK_CYCLES = wwdfr_pkg::TICK_CYCLES,
    parameter int P_ARM_TICKS = wwdfr_pkg::ARM_DELAY_TICKS,
    parameter int P_PULSE_TICKS = wwdfr_pkg::FAULT_PULSE_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_heartbeat_in,
    input wire logic i_wdog_enable_n,
    input wire logic i_regs_good,
    input wire logic i_monitor_reference_fault,
    input wire logic [wwdfr_pkg::ADJ_W-1:0] i_timeout_adjust,
    input wire logic i_reset_fault_n_in,
    output logic o_reset_fault_n_out,
    output logic o_reset_fault_n_oe,
    input wire logic i_five_volt_good_in,
    output logic o_five_volt_good_out,
    output logic o_five_volt_good_oe,
    output wwdfr_pkg::wwdfr_status_t o_status
);
    import wwdfr_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic hb_s;
    logic en_s;
    logic regs_s;
    logic mref_s;

    wwdfr_sync u_sync_hb (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_heartbeat_in),
        .o_sync(hb_s)
    );
    // Resets low, so the watchdog starts disarmed until enable is seen low
    wwdfr_sync u_sync_en (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(~i_wdog_enable_n),
        .o_sync(en_s)
    );
    wwdfr_sync u_sync_regs (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_regs_good),
        .o_sync(regs_s)
    );
    wwdfr_sync u_sync_mref (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_monitor_reference_fault),
        .o_sync(mref_s)
    );

    logic hb_d_reg;
    logic hb_edge;
    logic arm_ok;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            hb_d_reg <= 1'b0;
        end else begin
            hb_d_reg <= hb_s;
        end
    end

    assign hb_edge = hb_s & ~hb_d_reg;
    // en_s carries the inverted pin, so high means enabled
    assign arm_ok = en_s & regs_s;

    // ----------------------------------------
    // Tick divider
    // ----------------------------------------
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(P_TICK_CYCLES - 1);
    logic [DIV_W-1:0] div_reg;
    logic tick;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            div_reg <= DIV_ZERO;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= DIV_ZERO;
        end else begin
            div_reg <= div_reg + DIV_ONE;
        end
    end

    assign tick = (div_reg == DIV_LAST);

    // ----------------------------------------
    // Window from the timeout adjust setting
    // ----------------------------------------
    localparam logic [ADJ_W-1:0] ADJ_MIN = ADJ_W'(LATE_MIN_MS);
    localparam logic [ADJ_W-1:0] ADJ_MAX = ADJ_W'(LATE_MAX_MS);
    localparam logic [CNT_W-1:0] TPM = CNT_W'(TICKS_PER_MS);
    logic [ADJ_W-1:0] adj_ms;
    logic [CNT_W-1:0] late_ticks;
    logic [CNT_W-1:0] early_ticks;

    always_comb begin
        // Out-of-range settings clamp, like a resistor off the ends of the scale
        if (i_timeout_adjust < ADJ_MIN) begin
            adj_ms = ADJ_MIN;
        end else if (i_timeout_adjust > ADJ_MAX) begin
            adj_ms = ADJ_MAX;
        end else begin
            adj_ms = i_timeout_adjust;
        end
    end

    assign late_ticks = CNT_W'(32'(adj_ms) * 32'(TPM));
    assign early_ticks = late_ticks >> EARLY_SHIFT;

    // ----------------------------------------
    // Supervisor state
    // ----------------------------------------
    localparam logic [CNT_W-1:0] ARM_LAST = CNT_W'(P_ARM_TICKS - 1);
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(P_PULSE_TICKS - 1);
    wwdfr_state_t state_reg;
    wwdfr_state_t state_next;
    logic [CNT_W-1:0] ivl_reg;
    logic [CNT_W-1:0] tmr_reg;
    logic seen_reg;
    logic early_hit;
    logic late_hit;
    logic edge_ok;

    assign early_hit = (state_reg == ST_RUN) && hb_edge && seen_reg
                       && (ivl_reg < early_ticks);
    assign late_hit = (state_reg == ST_RUN) && !hb_edge && tick
                      && ((ivl_reg + CNT_ONE) >= late_ticks);
    assign edge_ok = (state_reg == ST_RUN) && hb_edge && !early_hit;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (arm_ok) begin
                    state_next = ST_ARM_WAIT;
                end
            end
            ST_ARM_WAIT: begin
                if (!arm_ok) begin
                    state_next = ST_OFF;
                end else if (tick && tmr_reg == ARM_LAST) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!arm_ok) begin
                    state_next = ST_OFF;
                end else if (early_hit || late_hit) begin
                    state_next = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (!arm_ok) begin
                    state_next = ST_OFF;
                end else if (tick && tmr_reg == PULSE_LAST) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Shared timer for arm delay and fault pulse; restarts on each state change
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            tmr_reg <= CNT_ZERO;
        end else if (state_next != state_reg) begin
            tmr_reg <= CNT_ZERO;
        end else if (tick && tmr_reg != CNT_MAX) begin
            tmr_reg <= tmr_reg + CNT_ONE;
        end
    end

    // Interval counter: only runs while armed, cleared by edges and faults
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ivl_reg <= CNT_ZERO;
        end else if (state_next != ST_RUN || state_reg != ST_RUN) begin
            ivl_reg <= CNT_ZERO;
        end else if (edge_ok) begin
            ivl_reg <= CNT_ZERO;
        end else if (tick && ivl_reg != CNT_MAX) begin
            ivl_reg <= ivl_reg + CNT_ONE;
        end
    end

    // First edge after arming has no predecessor, so it cannot be early
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            seen_reg <= 1'b0;
        end else if (state_reg != ST_RUN) begin
            seen_reg <= 1'b0;
        end else if (edge_ok) begin
            seen_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Fault outputs
    // ----------------------------------------
    logic rst_oe_reg;
    logic pok_oe_reg;
    wwdfr_status_t status_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rst_oe_reg <= 1'b0;
            pok_oe_reg <= 1'b0;
        end else begin
            rst_oe_reg <= (state_next == ST_PULSE) | mref_s;
            pok_oe_reg <= mref_s;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            status_reg <= '0;
        end else begin
            status_reg.armed <= (state_next == ST_RUN) || (state_next == ST_PULSE);
            status_reg.early_fault <= early_hit && arm_ok;
            status_reg.late_fault <= late_hit && arm_ok;
            status_reg.ref_fault <= mref_s;
        end
    end

    // Open-drain: the pin only ever sinks, the pull-up is external
    assign o_reset_fault_n_out = 1'b0;
    assign o_reset_fault_n_oe = rst_oe_reg;
    assign o_five_volt_good_out = 1'b0;
    assign o_five_volt_good_oe = pok_oe_reg;
    assign o_status = status_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    early_fault_a: assert property (
        (early_hit && arm_ok) |=> (state_reg == ST_PULSE) && o_status.early_fault
    ) else $error("early edge did not raise a fault");

    late_fault_a: assert property (
        (late_hit && arm_ok) |=> (state_reg == ST_PULSE) && o_status.late_fault
    ) else $error("late timeout did not raise a fault");

    window_ok_a: assert property (
        (edge_ok && seen_reg && arm_ok) |=> (state_reg == ST_RUN) && (ivl_reg == CNT_ZERO)
    ) else $error("in-window edge was not accepted");

    pulse_drive_a: assert property (
        (state_reg == ST_PULSE) |-> o_reset_fault_n_oe && !o_reset_fault_n_out
    ) else $error("reset not driven low during fault pulse");

    pulse_end_a: assert property (
        ($fell(state_reg == ST_PULSE) && $past(arm_ok)) |-> $past(tmr_reg) == PULSE_LAST
    ) else $error("fault pulse length wrong");

    early_ratio_a: assert property (
        ((early_ticks << EARLY_SHIFT) <= late_ticks)
        && ((late_ticks - (early_ticks << EARLY_SHIFT)) < CNT_W'(4))
    ) else $error("early threshold is not a quarter of late timeout");

    late_range_a: assert property (
        (late_ticks >= CNT_W'(LATE_MIN_MS * TICKS_PER_MS))
        && (late_ticks <= CNT_W'(LATE_MAX_MS * TICKS_PER_MS))
    ) else $error("late timeout out of range");

    arm_delay_a: assert property (
        $rose(state_reg == ST_RUN) && $past(state_reg) == ST_ARM_WAIT
        |-> $past(tmr_reg) == ARM_LAST && $past(tick)
    ) else $error("armed before activation delay");

    pulse_restart_a: assert property (
        ($fell(state_reg == ST_PULSE) && state_reg == ST_RUN)
        |-> (ivl_reg == CNT_ZERO) && !seen_reg
    ) else $error("counters not cleared after fault pulse");

    enable_disarm_a: assert property (
        !en_s |=> ((state_reg == ST_OFF) && (ivl_reg == CNT_ZERO)) ##1 !o_status.armed
    ) else $error("watchdog not disarmed while enable high");

    ref_fault_a: assert property (
        mref_s |=> o_reset_fault_n_oe && o_five_volt_good_oe
    ) else $error("reference fault not reported");

endmodule
